// file: src/dsw_cfg.svh
// Bit positions, widths and reset values of the drive status word packer.
// Included by the package and the packer; definitions only.
`ifndef DSW_CFG_SVH
`define DSW_CFG_SVH

`define DSW_WORD_W         32
`define DSW_FB_W           16
`define DSW_BIT_READY      0
`define DSW_BIT_RUN_EN     1
`define DSW_BIT_STARTED    2
`define DSW_BIT_MODULATING 3
`define DSW_BIT_STANDSTILL 4
`define DSW_BIT_RISING     5
`define DSW_BIT_FALLING    6
`define DSW_BIT_ON_TARGET  7
`define DSW_BIT_LIMITED    8
`define DSW_BIT_SUPERVISE  9
`define DSW_BIT_REV_REF    10
`define DSW_BIT_REV_ACT    11
`define DSW_BIT_PANEL_LOC  12
`define DSW_BIT_BUS_LOC    13
`define DSW_BIT_LOC_B      14
`define DSW_BIT_FAULT      15
`define DSW_BIT_WARNING    16
`define DSW_BIT_ROT_LOCK   18
`define DSW_BIT_KEY_LOCK   19
`define DSW_BIT_USER_LO    22
`define DSW_USER_W         4
`define DSW_BIT_CMD_GRANT  26
`define DSW_BIT_REF_GRANT  27
`define DSW_RESET_WORD     32'h0000_0000
`define DSW_RESET_FB       16'h0000
`define DSW_RESET_BIT      1'b0

`endif

// file: src/dsw_packer.sv
// Drive status word packer for the alternate control profile.
// Assumes all condition inputs are synchronous levels on clock_i.
`timescale 1ns/1ns
`include "dsw_cfg.svh"

module dsw_packer #(
    parameter int USER_W = `DSW_USER_W
) (
    // Clock and reset
    input  wire logic                     clock_i,
    input  wire logic                     srst_i,
    // Drive conditions
    input  wire logic                     ready_i,
    input  wire logic                     run_enable_i,
    input  wire logic                     started_i,
    input  wire logic                     modulating_i,
    input  wire logic                     standstill_i,
    input  wire logic                     speed_rising_i,
    input  wire logic                     speed_falling_i,
    input  wire logic                     on_target_i,
    input  wire logic                     limited_i,
    input  wire logic                     supervision_i,
    input  wire logic                     reverse_ref_i,
    input  wire logic                     reverse_act_i,
    input  wire logic                     panel_local_i,
    input  wire logic                     bus_local_i,
    input  wire logic                     second_location_selected_i,
    input  wire logic                     fault_i,
    input  wire logic                     warning_i,
    input  wire logic                     rotation_change_locked_i,
    input  wire logic                     keypad_mode_locked_i,
    input  wire logic [USER_W-1:0]        user_flags_i,
    input  wire logic                     channel_command_granted_i,
    input  wire logic                     channel_reference_granted_i,
    // Status words
    output logic      [`DSW_WORD_W-1:0]   drive_status_o,
    output logic      [`DSW_FB_W-1:0]     fieldbus_drive_status_o
);

    // One flop per status condition
    logic                  ready_r;
    logic                  run_enable_r;
    logic                  started_r;
    logic                  modulating_r;
    logic                  standstill_r;
    logic                  speed_rising_r;
    logic                  speed_falling_r;
    logic                  on_target_r;
    logic                  limited_r;
    logic                  supervision_r;
    logic                  reverse_ref_r;
    logic                  reverse_act_r;
    logic                  panel_local_r;
    logic                  bus_local_r;
    logic                  second_location_selected_r;
    logic                  fault_r;
    logic                  warning_r;
    logic                  rotation_change_locked_r;
    logic                  keypad_mode_locked_r;
    logic                  channel_command_granted_r;
    logic                  channel_reference_granted_r;
    logic                  user_r [USER_W];
    dsw_pkg::dsw_word_t    status_word;

    // Drive state group

    // Ready to accept a start
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ready_r <= `DSW_RESET_BIT;
        end
        else begin
            ready_r <= ready_i;
        end
    end

    // External run enable
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            run_enable_r <= `DSW_RESET_BIT;
        end
        else begin
            run_enable_r <= run_enable_i;
        end
    end

    // Start command received
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            started_r <= `DSW_RESET_BIT;
        end
        else begin
            started_r <= started_i;
        end
    end

    // Power stage modulating
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            modulating_r <= `DSW_RESET_BIT;
        end
        else begin
            modulating_r <= modulating_i;
        end
    end

    // Speed group

    // Zero speed
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            standstill_r <= `DSW_RESET_BIT;
        end
        else begin
            standstill_r <= standstill_i;
        end
    end

    // Speed rising
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            speed_rising_r <= `DSW_RESET_BIT;
        end
        else begin
            speed_rising_r <= speed_rising_i;
        end
    end

    // Speed falling
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            speed_falling_r <= `DSW_RESET_BIT;
        end
        else begin
            speed_falling_r <= speed_falling_i;
        end
    end

    // Setpoint reached
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            on_target_r <= `DSW_RESET_BIT;
        end
        else begin
            on_target_r <= on_target_i;
        end
    end

    // Operation limited
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            limited_r <= `DSW_RESET_BIT;
        end
        else begin
            limited_r <= limited_i;
        end
    end

    // Supervision limit exceeded
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            supervision_r <= `DSW_RESET_BIT;
        end
        else begin
            supervision_r <= supervision_i;
        end
    end

    // Direction group

    // Reference commands reverse
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            reverse_ref_r <= `DSW_RESET_BIT;
        end
        else begin
            reverse_ref_r <= reverse_ref_i;
        end
    end

    // Motor running reverse
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            reverse_act_r <= `DSW_RESET_BIT;
        end
        else begin
            reverse_act_r <= reverse_act_i;
        end
    end

    // Control location group

    // Panel or PC tool local
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            panel_local_r <= `DSW_RESET_BIT;
        end
        else begin
            panel_local_r <= panel_local_i;
        end
    end

    // Fieldbus local
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            bus_local_r <= `DSW_RESET_BIT;
        end
        else begin
            bus_local_r <= bus_local_i;
        end
    end

    // Second external location
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            second_location_selected_r <= `DSW_RESET_BIT;
        end
        else begin
            second_location_selected_r <= second_location_selected_i;
        end
    end

    // Fault and warning group

    // Tripped
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            fault_r <= `DSW_RESET_BIT;
        end
        else begin
            fault_r <= fault_i;
        end
    end

    // Warning active, internal word only
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            warning_r <= `DSW_RESET_BIT;
        end
        else begin
            warning_r <= warning_i;
        end
    end

    // Lock group

    // Direction change locked
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rotation_change_locked_r <= `DSW_RESET_BIT;
        end
        else begin
            rotation_change_locked_r <= rotation_change_locked_i;
        end
    end

    // Local mode locked
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            keypad_mode_locked_r <= `DSW_RESET_BIT;
        end
        else begin
            keypad_mode_locked_r <= keypad_mode_locked_i;
        end
    end

    // Channel grant group

    // Command granted to this channel
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            channel_command_granted_r <= `DSW_RESET_BIT;
        end
        else begin
            channel_command_granted_r <= channel_command_granted_i;
        end
    end

    // Reference granted to this channel
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            channel_reference_granted_r <= `DSW_RESET_BIT;
        end
        else begin
            channel_reference_granted_r <= channel_reference_granted_i;
        end
    end

    // Application flags share one flop template
    for (genvar gi = 0; gi < USER_W; gi++) begin : g_user
        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                user_r[gi] <= `DSW_RESET_BIT;
            end
            else begin
                user_r[gi] <= user_flags_i[gi];
            end
        end
    end

    // Wiring only, no gates: both words come from the same flops
    // Reserved bits start at zero and are never written
    always_comb begin
        status_word                              = `DSW_RESET_WORD;
        status_word[`DSW_BIT_READY]              = ready_r;
        status_word[`DSW_BIT_RUN_EN]             = run_enable_r;
        status_word[`DSW_BIT_STARTED]            = started_r;
        status_word[`DSW_BIT_MODULATING]         = modulating_r;
        status_word[`DSW_BIT_STANDSTILL]         = standstill_r;
        status_word[`DSW_BIT_RISING]             = speed_rising_r;
        status_word[`DSW_BIT_FALLING]            = speed_falling_r;
        status_word[`DSW_BIT_ON_TARGET]          = on_target_r;
        status_word[`DSW_BIT_LIMITED]            = limited_r;
        status_word[`DSW_BIT_SUPERVISE]          = supervision_r;
        status_word[`DSW_BIT_REV_REF]            = reverse_ref_r;
        status_word[`DSW_BIT_REV_ACT]            = reverse_act_r;
        status_word[`DSW_BIT_PANEL_LOC]          = panel_local_r;
        status_word[`DSW_BIT_BUS_LOC]            = bus_local_r;
        status_word[`DSW_BIT_LOC_B]              = second_location_selected_r;
        status_word[`DSW_BIT_FAULT]              = fault_r;
        status_word[`DSW_BIT_WARNING]            = warning_r;
        status_word[`DSW_BIT_ROT_LOCK]           = rotation_change_locked_r;
        status_word[`DSW_BIT_KEY_LOCK]           = keypad_mode_locked_r;
        for (int i = 0; i < USER_W; i++) begin
            status_word[`DSW_BIT_USER_LO + i]    = user_r[i];
        end
        status_word[`DSW_BIT_CMD_GRANT]          = channel_command_granted_r;
        status_word[`DSW_BIT_REF_GRANT]          = channel_reference_granted_r;
    end

    // Low half taken as is, so the fieldbus word never lags the internal one
    assign drive_status_o          = status_word;
    assign fieldbus_drive_status_o = status_word[`DSW_FB_W-1:0];

endmodule : dsw_packer

// file: src/dsw_pkg.sv
// Types shared by the drive status word packer.
// Assumes dsw_cfg.svh is on the include path.
`include "dsw_cfg.svh"

package dsw_pkg;
    typedef logic [`DSW_WORD_W-1:0] dsw_word_t;
    typedef logic [`DSW_FB_W-1:0]   dsw_fb_word_t;
endpackage : dsw_pkg

// file: verification/dsw_checker.sv
// Port checker for the drive status word packer.
// Bound to dsw_packer; one clock, synchronous reset.
`timescale 1ns/1ns
module dsw_chk #(parameter int USER_W = 4) (
    input wire logic clock_i, srst_i, ready_i, fault_i, warning_i, channel_command_granted_i,
    input wire logic [USER_W-1:0] user_flags_i,
    input wire logic [31:0] drive_status_o,
    input wire logic [15:0] fieldbus_drive_status_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    // Skip the first edge after reset, outputs still hold zero
    sequence s_on; !$past(srst_i); endsequence
    property p_fb; fieldbus_drive_status_o == drive_status_o[15:0]; endproperty
    a_fb: assert property (p_fb) else $error("fb copy");
    property p_rsv; {drive_status_o[31:28], drive_status_o[21:20], drive_status_o[17]} == 7'h00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved");
    property p_rst; $fell(srst_i) |-> drive_status_o == 32'h0000_0000; endproperty
    a_rst: assert property (p_rst) else $error("reset word");
    property p_rdy; s_on |-> drive_status_o[0] == $past(ready_i); endproperty
    a_rdy: assert property (p_rdy) else $error("ready");
    property p_flt; s_on |-> fieldbus_drive_status_o[15] == $past(fault_i); endproperty
    a_flt: assert property (p_flt) else $error("fault");
    property p_wrn; s_on |-> drive_status_o[16] == $past(warning_i); endproperty
    a_wrn: assert property (p_wrn) else $error("warning");
    property p_usr; s_on |-> drive_status_o[25:22] == $past(user_flags_i); endproperty
    a_usr: assert property (p_usr) else $error("user");
    property p_grt; s_on |-> drive_status_o[26] == $past(channel_command_granted_i); endproperty
    a_grt: assert property (p_grt) else $error("grant");
endmodule : dsw_chk
bind dsw_packer dsw_chk #(.USER_W(USER_W)) u_chk (.*);

// file: verification/dsw_fb_master.sv
// Fieldbus master model: reads the status word each cycle.
// Assumes a registered word on clock_i.
`timescale 1ns/1ns
module dsw_fb_master (
    input  wire logic        clock_i,
    input  wire logic [15:0] fb_word_i,
    output logic      [15:0] seen_word_o
);
    always_ff @(posedge clock_i) seen_word_o <= fb_word_i;
endmodule : dsw_fb_master

// file: verification/tb.sv
// Bench for the drive status word packer.
// Needs dsw_packer, dsw_fb_master and the bound checker.
`timescale 1ns/1ns
module tb;
    logic clock_i = 1'b0, srst_i = 1'b1;
    logic [31:0] s = 32'h0, ds;
    logic [15:0] fb, sw;
    int fail_count = 0, num_checks = 0, cyc = 0;
    always #25 clock_i = ~clock_i;
    // Reserved positions of s reach no input
    dsw_packer DUT (.clock_i(clock_i), .srst_i(srst_i), .ready_i(s[0]), .run_enable_i(s[1]),
        .started_i(s[2]), .modulating_i(s[3]), .standstill_i(s[4]), .speed_rising_i(s[5]),
        .speed_falling_i(s[6]), .on_target_i(s[7]), .limited_i(s[8]), .supervision_i(s[9]),
        .reverse_ref_i(s[10]), .reverse_act_i(s[11]), .panel_local_i(s[12]),
        .bus_local_i(s[13]), .second_location_selected_i(s[14]), .fault_i(s[15]),
        .warning_i(s[16]), .rotation_change_locked_i(s[18]), .keypad_mode_locked_i(s[19]),
        .user_flags_i(s[25:22]), .channel_command_granted_i(s[26]),
        .channel_reference_granted_i(s[27]), .drive_status_o(ds), .fieldbus_drive_status_o(fb));
    dsw_fb_master u_m (.clock_i(clock_i), .fb_word_i(fb), .seen_word_o(sw));
    task automatic close_out();
        $display("checks %0d fails %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // Two edges: one for the packer, one for the master
    task automatic apply(logic [31:0] v);
        @(negedge clock_i) s = v;
        repeat (2) @(negedge clock_i);
        chk("status", v & 32'h0fcd_ffff, ds);
        chk("fieldbus", {16'h0, v[15:0]}, {16'h0, fb});
        chk("master", {16'h0, v[15:0]}, {16'h0, sw});
    endtask : apply
    task automatic t_walk();
        for (int i = 0; i < 8; i++) apply(32'h1 << i);
        for (int i = 8; i < 16; i++) apply(32'h1 << i);
        for (int i = 16; i < 32; i++) apply(32'h1 << i);
        $display("walk done");
    endtask : t_walk
    task automatic t_edge();
        apply(32'hffff_ffff);
        apply(32'haaaa_aaaa);
        @(negedge clock_i) srst_i = 1'b1;
        @(negedge clock_i) srst_i = 1'b0;
        chk("reset", 32'h0, ds);
        apply(32'h0001_8000);
        $display("edge done");
    endtask : t_edge
    initial begin
        repeat (5) @(negedge clock_i);
        srst_i = 1'b0;
        t_walk();
        t_edge();
        close_out();
    end
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 500) begin
            fail_count++;
            close_out();
        end
    end
endmodule : tb
